// File: rtl/iodiag_pkg.sv
// Package: constants and carrier types of the I/O parameter/diagnosis block
package iodiag_pkg;

	// ************************************************
	// Widths
	// ************************************************
	localparam int unsigned CHAN_N   = 16;   // Output channels (sockets 1..8)
	localparam int unsigned HALF_N   = 8;    // Channels on sockets 1..4

	// ************************************************
	// Configuration byte and coding switch field positions
	// ************************************************
	localparam int unsigned CFG_OVL_LATCH_BIT = 0;  // Overload latch select
	localparam int unsigned CFG_DIAG_CHG_BIT  = 1;  // Change-report diagnosis
	localparam int unsigned CFG_FREEZE_BIT    = 3;  // Freeze on link failure
	localparam int unsigned SW_INPUT_BIT      = 3;  // Coding switch: inputs

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [7:0]  CFG_RST     = 8'h00;   // All defaults
	localparam logic [15:0] CHAN_RST    = 16'h0000;
	localparam logic [15:0] HALF_MASK   = 16'h00ff; // Sockets 1..4 always out

	// ************************************************
	// Start-up sequencer states
	// ************************************************
	typedef enum logic [2:0] {
		IOD_ST_PARAM  = 3'b001,  // Waiting for first parameter byte
		IOD_ST_SURVEY = 3'b010,  // Load survey at start-up
		IOD_ST_RUN    = 3'b100   // Cyclic operation
	} iod_state_t;

	// ************************************************
	// Diagnosis record: byte Z, then Z+1, Z+2
	// ************************************************
	typedef struct packed {
		logic        comm_lost;    // Byte Z bit 7
		logic [4:0]  rsvd;         // Byte Z bits 6..2, read as zero
		logic        valve_bad;    // Byte Z bit 1
		logic        sensor_ovl;   // Byte Z bit 0
		logic [15:0] chan_fault;   // Bytes Z+1, Z+2, one bit per output
	} iod_diag_t;

	localparam iod_diag_t DIAG_RST = '0;

endpackage

// File: rtl/iodiag_core.sv
// Module: parameter byte, output hold/clear and output diagnosis of an I/O node
`timescale 1ns/1ns
`default_nettype none

module iodiag_core
	import iodiag_pkg::*;
(
	input  wire logic              sys_clk_in,      // 25 MHz clock
	input  wire logic              rstn_in,         // Link power-up reset
	input  wire logic              cfg_valid_in,    // Parameter byte strobe
	input  wire logic [7:0]        cfg_byte_in,     // Parameter byte
	input  wire logic              link_ok_in,      // Link communication alive
	input  wire logic              out_strobe_in,   // Cyclic output data strobe
	input  wire logic [CHAN_N-1:0] out_data_in,     // Cyclic output data
	input  wire logic [3:0]        coding_switch_in,// Coding switch
	input  wire logic [CHAN_N-1:0] short_det_in,    // Raw short sense
	input  wire logic [CHAN_N-1:0] open_det_in,     // Raw open-load sense
	input  wire logic              sensor_ovl_in,   // Sensor supply overload
	input  wire logic              valve_bad_in,    // Valve supply out of range
	output logic [CHAN_N-1:0]      chan_drive_out,  // Output channel drive
	output logic [7:0]             cfg_readback_out,// Stored parameter byte
	output logic [7:0]             cfg_active_out,  // Parameters in force
	output iod_diag_t              diag_out,        // Diagnosis record
	output logic                   diag_send_out,   // Diagnosis message pulse
	output logic                   running_out      // Cyclic operation reached
);

	// ************************************************
	// State
	// ************************************************
	iod_state_t        state_r, state_nxt;          // Start-up sequencer
	logic [7:0]        cfg_store_r, cfg_store_nxt;  // Last byte received
	logic [7:0]        cfg_act_r, cfg_act_nxt;      // Byte in force
	logic [CHAN_N-1:0] drive_r, drive_nxt;          // Channel drive
	logic [CHAN_N-1:0] open_seen_r, open_seen_nxt;  // Open seen while idle
	logic [CHAN_N-1:0] sent_r, sent_nxt;            // Last reported map
	logic              ovl_r, ovl_nxt;              // Overload indication
	iod_diag_t         diag_r, diag_nxt;            // Diagnosis record
	logic              send_r, send_nxt;            // Message pulse

	// ************************************************
	// Decoded settings
	// ************************************************
	logic              freeze_mode;   // Hold outputs on link loss
	logic              chg_mode;      // Survey and change reports
	logic              ovl_latch;     // Sticky overload
	logic [CHAN_N-1:0] out_mask;      // Channels configured as outputs
	logic [CHAN_N-1:0] fault_map;     // Current per-channel faults

	// Only bits 0, 1, 3 are decoded; the rest are never looked at
	assign freeze_mode = cfg_act_r[CFG_FREEZE_BIT];
	assign chg_mode    = cfg_act_r[CFG_DIAG_CHG_BIT];
	assign ovl_latch   = cfg_act_r[CFG_OVL_LATCH_BIT];

	// Sockets 5..8 become inputs and lose their outputs
	assign out_mask = coding_switch_in[SW_INPUT_BIT] ? HALF_MASK : ~CHAN_RST;

	// ************************************************
	// Per-channel fault detection
	// ************************************************
	genvar gi;
	generate
		for (gi = 0; gi < CHAN_N; gi++) begin : g_chan
			logic short_f;  // Short while driven
			logic open_f;   // Open while idle
			// Short sense is meaningless while undriven
			assign short_f = drive_r[gi] & short_det_in[gi];
			// Open sense is meaningless while driven
			assign open_f  = ~drive_r[gi] & open_det_in[gi];
			// Change mode reports idle open at once
			// Default mode blames a missing load once driven
			assign fault_map[gi] = out_mask[gi] & (short_f |
				(chg_mode ? open_f : (drive_r[gi] & open_seen_r[gi])));
		end
	endgenerate

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb begin
		state_nxt     = state_r;
		cfg_store_nxt = cfg_store_r;
		cfg_act_nxt   = cfg_act_r;
		drive_nxt     = drive_r;
		sent_nxt      = sent_r;
		send_nxt      = 1'b0;
		// Any non-cyclic byte is kept for readback; the first also becomes the settings
		if (cfg_valid_in) begin
			cfg_store_nxt = cfg_byte_in;
		end
		// Remember an open load while the channel rests
		open_seen_nxt = (open_seen_r & drive_r) | (open_det_in & ~drive_r);
		// Overload: latched or following the cause
		ovl_nxt = sensor_ovl_in | (ovl_latch & ovl_r);
		unique case (state_r)
			IOD_ST_PARAM: begin
				drive_nxt = CHAN_RST;
				// First byte after power-up becomes the settings
				if (cfg_valid_in) begin
					cfg_act_nxt = cfg_byte_in;
					state_nxt   = cfg_byte_in[CFG_DIAG_CHG_BIT] ?
						IOD_ST_SURVEY : IOD_ST_RUN;
				end
			end
			IOD_ST_SURVEY: begin
				// Outputs idle: open sense shows missing loads
				sent_nxt  = fault_map;
				send_nxt  = 1'b1;
				state_nxt = IOD_ST_RUN;
			end
			IOD_ST_RUN: begin
				// Later bytes never touch the settings in force
				if (!link_ok_in) begin
					// Clear or freeze on link failure
					drive_nxt = freeze_mode ? drive_r : CHAN_RST;
				end else if (out_strobe_in) begin
					drive_nxt = out_data_in & out_mask;
				end
				if (chg_mode) begin
					// Message only on a change of the map
					if (fault_map != sent_r) begin
						sent_nxt = fault_map;
						send_nxt = 1'b1;
					end
				end else begin
					// Report with each output cycle
					send_nxt = out_strobe_in;
					sent_nxt = fault_map;
				end
			end
		endcase
		// Record carries the whole range every time
		diag_nxt            = DIAG_RST;
		diag_nxt.comm_lost  = ~link_ok_in;
		diag_nxt.valve_bad  = valve_bad_in;
		diag_nxt.sensor_ovl = ovl_nxt;
		diag_nxt.chan_fault = sent_nxt;
	end

	// ************************************************
	// Registers
	// ************************************************
	// Reset stands for an interruption of link power, so it is the only
	// thing that clears a latched overload or lets new settings in.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r     <= IOD_ST_PARAM;
			cfg_store_r <= CFG_RST;
			cfg_act_r   <= CFG_RST;
			drive_r     <= CHAN_RST;
			open_seen_r <= CHAN_RST;
			sent_r      <= CHAN_RST;
			ovl_r       <= 1'b0;
			diag_r      <= DIAG_RST;
			send_r      <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			cfg_store_r <= cfg_store_nxt;
			cfg_act_r   <= cfg_act_nxt;
			drive_r     <= drive_nxt;
			open_seen_r <= open_seen_nxt;
			sent_r      <= sent_nxt;
			ovl_r       <= ovl_nxt;
			diag_r      <= diag_nxt;
			send_r      <= send_nxt;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign chan_drive_out   = drive_r;
	assign cfg_readback_out = cfg_store_r;
	assign cfg_active_out   = cfg_act_r;
	assign diag_out         = diag_r;
	assign diag_send_out    = send_r;
	assign running_out      = (state_r == IOD_ST_RUN);

	// ************************************************
	// Assertions
	// ************************************************
	// All of them sleep during reset; a reset in mid-run aborts any
	// check still in flight, since reset stands for a power cut.
	short_gate_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(~chg_mode && state_r == IOD_ST_RUN && (~drive_r & ~open_seen_r) != 0)
		|=> ((diag_r.chan_fault & ~$past(drive_r)) == 0) || send_r == 1'b0)
		else $error("fault reported on idle channel in default mode");

	open_gate_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_r == IOD_ST_RUN && chg_mode && drive_r == out_mask &&
		 short_det_in == 16'h0000) |-> fault_map == 16'h0000)
		else $error("open load seen on a driven channel");

	clear_fail_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_r == IOD_ST_RUN && !link_ok_in && !freeze_mode)
		|=> chan_drive_out == 16'h0000)
		else $error("outputs not cleared on link failure");

	freeze_fail_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_r == IOD_ST_RUN && !link_ok_in && freeze_mode)
		|=> $stable(chan_drive_out))
		else $error("outputs not frozen on link failure");

	survey_send_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		state_r == IOD_ST_SURVEY |=> send_r && running_out &&
			diag_r.chan_fault == $past(fault_map))
		else $error("no survey message");

	change_only_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_r == IOD_ST_RUN && chg_mode && $past(state_r) == IOD_ST_RUN)
		|-> send_r == (diag_r.chan_fault != $past(diag_r.chan_fault)))
		else $error("change report mismatch");

	ovl_auto_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(!ovl_latch && !sensor_ovl_in) |=> !diag_r.sensor_ovl)
		else $error("overload not cleared automatically");

	ovl_latch_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(ovl_latch && ovl_r) |=> ovl_r)
		else $error("latched overload dropped");

	cfg_hold_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		state_r != IOD_ST_PARAM |=> $stable(cfg_act_r))
		else $error("settings changed without restart");

	switch_in_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(coding_switch_in[SW_INPUT_BIT] && state_r == IOD_ST_RUN &&
		 link_ok_in && out_strobe_in) |=> chan_drive_out[15:8] == 8'h00)
		else $error("input sockets driven");

	comm_flag_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		!link_ok_in |=> diag_r.comm_lost && diag_r.rsvd == 5'h00)
		else $error("link loss not flagged");

	// Every byte, early or late, reaches the readback
	cfg_readback_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		cfg_valid_in |=> cfg_readback_out == $past(cfg_byte_in))
		else $error("parameter byte not kept for readback");

	// Live link: a strobed word drives only output sockets
	data_take_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_r == IOD_ST_RUN && link_ok_in && out_strobe_in)
		|=> chan_drive_out == $past(out_data_in & out_mask))
		else $error("output data not applied");

	// Default mode: one message per output cycle, none between
	default_send_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_r == IOD_ST_RUN && !chg_mode)
		|=> diag_send_out == $past(out_strobe_in))
		else $error("default report not tied to output cycle");

	// Change mode: an idle open shows without any drive
	idle_open_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(state_r == IOD_ST_RUN && chg_mode)
		|-> (fault_map & ~drive_r) ==
			(open_det_in & out_mask & ~drive_r))
		else $error("idle open load not shown at once");

	// Input sockets never carry an output fault
	input_fault_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		coding_switch_in[SW_INPUT_BIT] |-> fault_map[15:8] == 8'h00)
		else $error("fault reported on an input socket");

	// Link flag drops again once the link is back
	comm_ok_a: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		link_ok_in |=> !diag_r.comm_lost)
		else $error("link loss flag stuck");

endmodule

`default_nettype wire

// File: sim/iodiag_coupler.sv
// Coupler model: parameter bytes, one per transfer and any number per node, and cyclic output words
`timescale 1ns/1ns
`default_nettype none

module iodiag_coupler
	import iodiag_pkg::*;
(
	input  wire logic              sys_clk_in,     // Link clock
	output logic                   cfg_valid_out,  // Parameter strobe
	output logic [7:0]             cfg_byte_out,   // Parameter byte
	output logic                   out_strobe_out, // Output data strobe
	output logic [CHAN_N-1:0]      out_data_out    // Output data
);
	// ****************************************
	// Idle levels
	// ****************************************
	// Released lines carry inverted data so stale values never pass
	initial begin
		cfg_valid_out  = 1'b0;
		cfg_byte_out   = 8'h5a;
		out_strobe_out = 1'b0;
		out_data_out   = 16'ha5a5;
	end

	// ****************************************
	// Transfers
	// ****************************************
	// One byte, sent once, outside the cyclic traffic
	task automatic send_cfg(input logic [7:0] b, input int gap);
		repeat (gap) @(posedge sys_clk_in);
		cfg_byte_out  <= b;
		cfg_valid_out <= 1'b1;
		@(posedge sys_clk_in);
		cfg_valid_out <= 1'b0;
		cfg_byte_out  <= ~b;
	endtask

	// Cyclic word; gap picks a prompt or a slow answer
	task automatic send_data(input logic [CHAN_N-1:0] d, input int gap);
		repeat (gap) @(posedge sys_clk_in);
		out_data_out   <= d;
		out_strobe_out <= 1'b1;
		@(posedge sys_clk_in);
		out_strobe_out <= 1'b0;
		out_data_out   <= ~d;
	endtask
endmodule

`default_nettype wire

// File: sim/testbench.sv
// Testbench: parameter, output hold and diagnosis of the I/O node
`timescale 1ns/1ns
`default_nettype none

module testbench
	import iodiag_pkg::*;
	;
	// ****************************************
	// Stimulus and model state
	// ****************************************
	logic              clk       = 1'b0;     // 25 MHz clock
	logic              rstn      = 1'b0;     // Power reset, active low
	logic              link_ok   = 1'b1;     // Link alive
	logic              ovl       = 1'b0;     // Sensor overload
	logic              valve     = 1'b0;     // Valve supply bad
	logic [3:0]        sw        = 4'h0;     // Coding switch
	logic [CHAN_N-1:0] short_det = CHAN_RST; // Short sense
	logic [CHAN_N-1:0] open_det  = CHAN_RST; // Open sense
	logic              cfg_valid, strobe, send, running;
	logic [7:0]        cfg_byte, cfg_rb, cfg_act;
	logic [CHAN_N-1:0] data, drive, d, prev;
	iod_diag_t         diag;                 // Diagnosis record
	logic [CHAN_N-1:0] m_drv, m_open;        // Model drive, idle open
	logic [7:0]        m_act, m_rb;          // Model parameter bytes
	logic              m_got;                // Model: byte taken
	logic              m_lost;               // Model: link loss flag
	logic [31:0]       seed      = 32'h00016894;
	int                n_errors  = 0;
	int                checks    = 0;
	int                cyc       = 0;

	always #20 clk = ~clk;  // 40 ns period

	iodiag_core u_iodiag_core (
		.sys_clk_in(clk), .rstn_in(rstn), .cfg_valid_in(cfg_valid),
		.cfg_byte_in(cfg_byte), .link_ok_in(link_ok),
		.out_strobe_in(strobe), .out_data_in(data),
		.coding_switch_in(sw), .short_det_in(short_det),
		.open_det_in(open_det), .sensor_ovl_in(ovl),
		.valve_bad_in(valve), .chan_drive_out(drive),
		.cfg_readback_out(cfg_rb), .cfg_active_out(cfg_act),
		.diag_out(diag), .diag_send_out(send), .running_out(running));

	iodiag_coupler u_iodiag_coupler (
		.sys_clk_in(clk), .cfg_valid_out(cfg_valid),
		.cfg_byte_out(cfg_byte), .out_strobe_out(strobe),
		.out_data_out(data));

	// ****************************************
	// Reference model
	// ****************************************
	function automatic logic [15:0] msk();
		return sw[SW_INPUT_BIT] ? HALF_MASK : 16'hffff;
	endfunction

	// Expected fault map; default mode keeps open seen while idle
	function automatic logic [15:0] fexp();
		if (m_act[CFG_DIAG_CHG_BIT])
			return (m_drv & short_det) | (~m_drv & open_det & msk());
		return m_drv & (short_det | m_open);
	endfunction

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			m_drv  <= CHAN_RST;
			m_open <= CHAN_RST;
			m_act  <= CFG_RST;
			m_rb   <= CFG_RST;
			m_got  <= 1'b0;
			m_lost <= 1'b0;
		end else begin
			if (cfg_valid)
				m_rb <= cfg_byte;
			if (cfg_valid && !m_got)
				m_act <= cfg_byte;  // First byte only
			m_got <= m_got | cfg_valid;
			m_lost <= ~link_ok;  // Flag one cycle late
			if (m_got && link_ok && strobe)
				m_drv <= data & msk();
			else if (!link_ok && !m_act[CFG_FREEZE_BIT])
				m_drv <= CHAN_RST;  // Cleared, else frozen
			m_open <= (m_drv & m_open) | (~m_drv & open_det);
		end
	end

	// Every cycle, once outputs have settled
	always @(negedge clk) begin
		chk("drive", 24'(m_drv), 24'(drive));
		chk("active", 24'(m_act), 24'(cfg_act));
		chk("readback", 24'(m_rb), 24'(cfg_rb));
		chk("link", 24'(m_lost), 24'(diag.comm_lost));
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [23:0] e,
			input logic [23:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %0s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Bounded wait for one message; a timeout shows as a mismatch
	task automatic get_msg(input logic m);
		int i;
		i = 0;
		@(negedge clk);
		while (send !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		chk("message", 24'h1, 24'(send));
		if (m)
			chk("fault map", 24'(fexp()), 24'(diag.chan_fault));
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge clk);
			chk("no message", 24'h0, 24'(send));
		end
	endtask

	// Change mode: one message only if the map moved, else silence
	task automatic settle();
		@(negedge clk);
		if (fexp() !== prev)
			get_msg(1'b1);
		quiet(5);
	endtask

	task automatic boot(input logic [7:0] c, input logic [3:0] s,
			input logic [15:0] o);
		rstn      <= 1'b0;
		sw        <= s;
		open_det  <= o;
		short_det <= CHAN_RST;
		link_ok   <= 1'b1;
		ovl       <= 1'b0;
		tick(4);
		rstn <= 1'b1;
		u_iodiag_coupler.send_cfg(c, 1);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			finish_test();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		boot(8'h00, 4'h0, 16'h0003);
		d = 16'(xs()) | 16'h0001;
		short_det <= 16'(xs());
		ovl       <= 1'b1;
		u_iodiag_coupler.send_data(d, 1);
		get_msg(1'b0);
		u_iodiag_coupler.send_data(d, 3);
		get_msg(1'b1);
		chk("overload", 24'h1, 24'(diag.sensor_ovl));
		tick(1);
		ovl <= 1'b0;
		u_iodiag_coupler.send_data(d, 3);
		get_msg(1'b1);
		chk("overload", 24'h0, 24'(diag.sensor_ovl));
		tick(1);
		link_ok <= 1'b0;
		u_iodiag_coupler.send_data(16'(xs()), 2);
		u_iodiag_coupler.send_cfg(8'h08, 0);
		tick(4);
		$display("test default done");
		boot(8'hfb, 4'h8, 16'h0f0f);
		valve <= 1'b1;
		get_msg(1'b1);
		chk("running", 24'h1, 24'(running));
		repeat (4) begin
			prev = fexp();
			u_iodiag_coupler.send_data(16'(xs()), 1);
			settle();
			tick(1);
			prev = fexp();
			short_det <= 16'(xs());
			settle();
			tick(1);
			prev = fexp();
			open_det <= 16'(xs());
			settle();
		end
		tick(1);
		ovl <= 1'b1;
		tick(2);
		ovl <= 1'b0;
		tick(4);
		@(negedge clk);
		chk("supply", 24'h3, {22'h0, diag.valve_bad, diag.sensor_ovl});
		tick(1);
		link_ok <= 1'b0;
		tick(4);
		@(negedge clk);
		chk("link lost", 24'h1, 24'(diag.comm_lost));
		tick(1);
		rstn <= 1'b0;
		tick(2);
		rstn <= 1'b1;
		tick(2);
		@(negedge clk);
		chk("overload", 24'h0, 24'(diag.sensor_ovl));
		$display("test change done");
		finish_test();
	end
endmodule

`default_nettype wire
